// *** logic/ack_sequencer.sv ***
// Function
// - setting ack_cycle_go starts an acknowledge cycle on the bus.
// - the SDA level of the cycle is ack_level_select, zero for ACK, one for NACK.
// - at the start SCL is held low and the chosen level is put on SDA.
// - the rate counter loads rate_reload_reg low seven bits, runs one period, then SCL is freed.
// - after SCL is seen high, allowing stretching, the counter reloads and runs a second period.
// - at the end SCL is driven low, ack_cycle_go clears, the counter stops, the port idles.
// - a transfer_buffer write during a cycle is dropped and sets write_clash_flag.
// - a rate period is four clocks times the reload value plus one.
`timescale 1ns/10ps
`default_nettype none
`include "ack_seq_consts.svh"
module ack_sequencer
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    logic       scl_lvl_ff;
    logic       sda_lvl_ff;
    logic       nxt_scl_lvl;
    logic       nxt_sda_lvl;

    always_comb
    begin
        nxt_scl_lvl = scl_lvl_ff;
        nxt_sda_lvl = sda_lvl_ff;
        if (scl_sync_ff[1] == scl_sync_ff[2])
        begin
            nxt_scl_lvl = scl_sync_ff[2];
        end
        if (sda_sync_ff[1] == sda_sync_ff[2])
        begin
            nxt_sda_lvl = sda_sync_ff[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_lvl_ff  <= 1'b1;
            sda_lvl_ff  <= 1'b1;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
            scl_lvl_ff  <= nxt_scl_lvl;
            sda_lvl_ff  <= nxt_sda_lvl;
        end
    end

    // ****************************************************************
    // registers and sequencer
    // ****************************************************************
    rate_if rif ();

    rate_counter u_rate
    (
        .pclk    (pclk),
        .presetn (presetn),
        .rif     (rif)
    );

    ack_seq_pkg::ack_state_t state_ff;
    ack_seq_pkg::ack_state_t nxt_state;
    logic       go_ff;
    logic       nxt_go;
    logic       level_ff;
    logic       nxt_level;
    logic [6:0] rate_ff;
    logic [6:0] nxt_rate;
    logic [7:0] buf_ff;
    logic [7:0] nxt_buf;
    logic       clash_ff;
    logic       nxt_clash;
    logic       scl_low_ff;
    logic       nxt_scl_low;
    logic       sda_low_ff;
    logic       nxt_sda_low;
    logic       wr_en;
    logic       busy;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    assign wr_en   = psel && penable && pwrite;
    assign busy    = (state_ff != ack_seq_pkg::ST_IDLE);
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_low_ff;
    assign sda_oe  = sda_low_ff;
    assign rif.reload = rate_ff;

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_go      = go_ff;
        nxt_level   = level_ff;
        nxt_rate    = rate_ff;
        nxt_buf     = buf_ff;
        nxt_clash   = clash_ff;
        nxt_scl_low = scl_low_ff;
        nxt_sda_low = sda_low_ff;
        rif.load    = 1'b0;
        rif.stop    = 1'b0;
        if (wr_en && hit(paddr, `REG_CONTROL_TWO) && !busy)
        begin
            nxt_go    = pwdata[`BIT_ACK_GO];
            nxt_level = pwdata[`BIT_ACK_LEVEL];
        end
        if (wr_en && hit(paddr, `REG_RATE_RELOAD))
        begin
            nxt_rate = pwdata[`RATE_BITS-1:0];
        end
        if (wr_en && hit(paddr, `REG_STATUS) && pwdata[`BIT_CLASH])
        begin
            nxt_clash = 1'b0;
        end
        if (wr_en && hit(paddr, `REG_BUFFER))
        begin
            if (busy)
            begin
                nxt_clash = 1'b1;
            end
            else
            begin
                nxt_buf = pwdata[7:0];
            end
        end
        case (state_ff)
            ack_seq_pkg::ST_IDLE:
            begin
                if (go_ff)
                begin
                    nxt_scl_low = 1'b1;
                    nxt_sda_low = !level_ff;
                    rif.load  = 1'b1;
                    nxt_state = ack_seq_pkg::ST_LOW;
                end
            end
            ack_seq_pkg::ST_LOW:
            begin
                if (rif.expired)
                begin
                    nxt_scl_low = 1'b0;
                    nxt_state   = ack_seq_pkg::ST_WAIT;
                end
            end
            ack_seq_pkg::ST_WAIT:
            begin
                if (scl_lvl_ff && !scl_low_ff)
                begin
                    rif.load  = 1'b1;
                    nxt_state = ack_seq_pkg::ST_HIGH;
                end
            end
            ack_seq_pkg::ST_HIGH:
            begin
                if (rif.expired)
                begin
                    nxt_scl_low = 1'b1;
                    nxt_go      = 1'b0;
                    rif.stop    = 1'b1;
                    nxt_state   = ack_seq_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ack_seq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= ack_seq_pkg::ST_IDLE;
            go_ff      <= 1'b0;
            level_ff   <= 1'b0;
            rate_ff    <= `RATE_RESET;
            buf_ff     <= 8'h00;
            clash_ff   <= 1'b0;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            go_ff      <= nxt_go;
            level_ff   <= nxt_level;
            rate_ff    <= nxt_rate;
            buf_ff     <= nxt_buf;
            clash_ff   <= nxt_clash;
            scl_low_ff <= nxt_scl_low;
            sda_low_ff <= nxt_sda_low;
        end
    end

    // ****************************************************************
    // read mux, registered
    // ****************************************************************
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    assign prdata = prdata_ff;

    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (psel && !penable && !pwrite)
        begin
            nxt_prdata = 32'h0;
            if (hit(paddr, `REG_CONTROL_TWO))
            begin
                nxt_prdata[`BIT_ACK_GO]    = go_ff;
                nxt_prdata[`BIT_ACK_LEVEL] = level_ff;
            end
            else if (hit(paddr, `REG_RATE_RELOAD))
            begin
                nxt_prdata[6:0] = rate_ff;
            end
            else if (hit(paddr, `REG_BUFFER))
            begin
                nxt_prdata[7:0] = buf_ff;
            end
            else if (hit(paddr, `REG_STATUS))
            begin
                nxt_prdata[`BIT_CLASH]  = clash_ff;
                nxt_prdata[`BIT_BUSY]   = busy;
                nxt_prdata[`BIT_SCL_IN] = scl_lvl_ff;
                nxt_prdata[`BIT_SDA_IN] = sda_lvl_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
        end
    end
endmodule
`default_nettype wire

// *** logic/rate_counter.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ack_seq_consts.svh"
module rate_counter
(
    input  wire logic pclk,
    input  wire logic presetn,
    rate_if.cnt       rif
);
    // ****************************************************************
    // period of (reload+1) ticks, each tick OSC_PER_RATE_TICK clocks
    // ****************************************************************
    logic [1:0] pre_ff;
    logic [1:0] nxt_pre;
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic       run_ff;
    logic       nxt_run;
    logic       exp_ff;
    logic       nxt_exp;

    assign rif.expired = exp_ff;

    always_comb
    begin
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        nxt_exp = 1'b0;
        if (rif.stop)
        begin
            nxt_run = 1'b0;
        end
        else if (rif.load)
        begin
            nxt_run = 1'b1;
            nxt_pre = 2'(`OSC_PER_RATE_TICK - 1);
            nxt_cnt = rif.reload;
        end
        else if (run_ff)
        begin
            if (pre_ff != 2'h0)
            begin
                nxt_pre = pre_ff - 2'h1;
            end
            else if (cnt_ff != 7'h00)
            begin
                nxt_pre = 2'(`OSC_PER_RATE_TICK - 1);
                nxt_cnt = cnt_ff - 7'h01;
            end
            else
            begin
                nxt_run = 1'b0;
                nxt_exp = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_ff <= 2'h0;
            cnt_ff <= 7'h00;
            run_ff <= 1'b0;
            exp_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
            exp_ff <= nxt_exp;
        end
    end
endmodule
`default_nettype wire

// *** pkg/ack_seq_consts.svh ***
`ifndef ACK_SEQ_CONSTS_SVH
`define ACK_SEQ_CONSTS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define REG_CONTROL_TWO   12'h000
`define REG_RATE_RELOAD   12'h004
`define REG_BUFFER        12'h008
`define REG_STATUS        12'h00c

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_ACK_GO        4
`define BIT_ACK_LEVEL     5
`define BIT_CLASH         0
`define BIT_BUSY          1
`define BIT_SCL_IN        2
`define BIT_SDA_IN        3
`define RATE_BITS         7

// ****************************************************************
// reset values and timing
// ****************************************************************
`define RATE_RESET        7'h00
`define OSC_PER_RATE_TICK 4

`endif

// *** pkg/ack_seq_pkg.sv ***
`default_nettype none
package ack_seq_pkg;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_WAIT = 2'b10,
        ST_HIGH = 2'b11
    } ack_state_t;
endpackage
`default_nettype wire

// *** pkg/rate_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface rate_if;
    logic       load;
    logic       stop;
    logic [6:0] reload;
    logic       expired;
    modport ctl (output load, output stop, output reload, input expired);
    modport cnt (input load, input stop, input reload, output expired);
endinterface
`default_nettype wire

// *** testbench/ack_seq_props.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ack_seq_consts.svh"
module ack_seq_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        scl_in,
    input wire logic        scl_oe,
    input wire logic        sda_oe
);
    // ****
    // phase tracker: 0 idle, 1 low phase, 2 released
    // ****
    logic [1:0] ph_ff, nxt_ph;
    logic [6:0] rate_ff, nxt_rate;
    logic       lvl_ff, nxt_lvl, oe_ff, wr, go;
    logic [9:0] cnt_ff, nxt_cnt, per;
    assign wr  = psel && penable && pwrite;
    assign go  = wr && ph_ff == 2'h0 && paddr == `REG_CONTROL_TWO && pwdata[`BIT_ACK_GO];
    assign per = {1'h0, rate_ff, 2'h0} + 10'h004;
    always_comb
    begin
        nxt_ph   = ph_ff;
        nxt_rate = (wr && paddr == `REG_RATE_RELOAD) ? pwdata[6:0] : rate_ff;
        nxt_lvl  = go ? pwdata[`BIT_ACK_LEVEL] : lvl_ff;
        // phase 2 counts scl seen high, so stretching restarts the count
        nxt_cnt  = ((ph_ff == 2'h2) ? scl_in : scl_oe) ? cnt_ff + 10'h001 : 10'h000;
        if (go)
        begin
            nxt_ph  = 2'h1;
            nxt_cnt = 10'h000;
        end
        if (ph_ff == 2'h1 && oe_ff && !scl_oe)
            nxt_ph = 2'h2;
        if (ph_ff == 2'h2 && scl_oe)
            nxt_ph = 2'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {ph_ff, rate_ff, lvl_ff, oe_ff, cnt_ff} <= '0;
        else
            {ph_ff, rate_ff, lvl_ff, oe_ff, cnt_ff} <= {nxt_ph, nxt_rate, nxt_lvl, scl_oe, nxt_cnt};
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence go_req;
        go;
    endsequence
    sequence drive_ack;
        scl_oe && sda_oe != lvl_ff;
    endsequence
    chk_go_start: assert property (go_req |=> ##[0:2] drive_ack)
        else $error("ack cycle did not start");
    chk_low_len: assert property ($fell(scl_oe) && ph_ff == 2'h1 |->
        cnt_ff >= per && cnt_ff <= per + 10'h004) else $error("low phase length wrong");
    chk_high_len: assert property ($rose(scl_oe) && ph_ff == 2'h2 |->
        cnt_ff >= per && cnt_ff <= per + 10'h007) else $error("high phase length wrong");
    chk_stretch_wait: assert property (ph_ff == 2'h2 && !scl_in && !scl_oe |->
        ##1 !scl_oe) else $error("scl pulled while slave holds it");
    chk_sda_hold: assert property (ph_ff == 2'h2 |-> sda_oe != lvl_ff)
        else $error("sda level lost");
    chk_idle_quiet: assert property (ph_ff == 2'h0 && !scl_oe |=> !scl_oe)
        else $error("scl driven without request");
    chk_end_held: assert property (ph_ff == 2'h0 && scl_oe |=> scl_oe)
        else $error("scl not kept low after cycle");
    chk_busy_read: assert property (ph_ff == 2'h2 && psel && !penable && !pwrite &&
        !scl_oe && paddr == `REG_STATUS |=> prdata[`BIT_BUSY]) else $error("busy not shown");
endmodule
bind ack_sequencer ack_seq_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .scl_in, .scl_oe, .sda_oe);
`default_nettype wire

// *** testbench/i2c_master_ack_sequencer_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ack_seq_consts.svh"
`define chk_eq(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module i2c_master_ack_sequencer_test;
    typedef struct {logic [6:0] rate; logic lvl; logic [3:0] st;} row_t;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, scl_in, scl_oe, sda_in, sda_oe, hold;
    logic [3:0]  stretch = 4'h0;
    int          failures = 0, comparisons = 0, cycles = 0;
    row_t        rows [3] = '{'{7'h00, 1'h0, 4'h9}, '{7'h03, 1'h1, 4'h5}, '{7'h7f, 1'h0, 4'h0}};
    // open-drain lines: sda has only a pull-up while the slave listens
    assign scl_in = !(scl_oe || hold);
    assign sda_in = !sda_oe;
    ack_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .scl_in, .scl_out(), .scl_oe, .sda_in, .sda_out(), .sda_oe);
    i2c_slave_model slave (.pclk, .presetn, .master_oe(scl_oe), .stretch, .scl_hold(hold));
    initial forever #2.5 pclk = ~pclk;
    // ****
    // bus tasks
    // ****
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        `chk_eq("pslverr", 1'h0, pslverr)
        {psel, penable} <= 2'h0;
    endtask
    task automatic wait_idle;
        do apb(1'h0, `REG_STATUS, 32'h0); while (q[`BIT_BUSY] !== 1'h0);
    endtask
    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            $display("[ERR] timeout exp done got hang");
            final_report;
        end
    end
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `REG_RATE_RELOAD, 32'h0);
        `chk_eq("rate reset", 32'h0, q)
        apb(1'h0, 12'h010, 32'h0);
        `chk_eq("unmapped", 32'h0, q)
        `chk_eq("pready", 1'h1, pready)
        $display("test reset done");
        foreach (rows[i])
        begin
            stretch <= rows[i].st;
            apb(1'h1, `REG_RATE_RELOAD, {25'h0, rows[i].rate});
            apb(1'h1, `REG_CONTROL_TWO, {26'h0, rows[i].lvl, 5'h10});
            apb(1'h0, `REG_STATUS, 32'h0);
            `chk_eq("busy", 1'h1, q[`BIT_BUSY])
            `chk_eq("sda", !rows[i].lvl, sda_oe)
            `chk_eq("scl", 1'h1, scl_oe)
            wait_idle;
            `chk_eq("scl end", 1'h1, scl_oe)
            apb(1'h0, `REG_CONTROL_TWO, 32'h0);
            `chk_eq("go clear", 1'h0, q[`BIT_ACK_GO])
            apb(1'h0, `REG_RATE_RELOAD, 32'h0);
            `chk_eq("rate", {25'h0, rows[i].rate}, q)
            apb(1'h0, `REG_STATUS, 32'h0);
            `chk_eq("scl level", 1'h0, q[`BIT_SCL_IN])
            `chk_eq("sda level", rows[i].lvl, q[`BIT_SDA_IN])
            $display("test row %0d done", i);
        end
        apb(1'h1, `REG_BUFFER, 32'h5a);
        apb(1'h1, `REG_CONTROL_TWO, 32'h10);
        apb(1'h1, `REG_BUFFER, 32'ha5);
        wait_idle;
        `chk_eq("clash", 1'h1, q[`BIT_CLASH])
        apb(1'h0, `REG_BUFFER, 32'h0);
        `chk_eq("buffer", 32'h5a, q)
        apb(1'h1, `REG_STATUS, 32'h1);
        apb(1'h0, `REG_STATUS, 32'h0);
        `chk_eq("clash clear", 1'h0, q[`BIT_CLASH])
        $display("test clash done");
        apb(1'h1, `REG_CONTROL_TWO, 32'h30);
        repeat (4) @(posedge pclk);
        presetn <= 1'h0;
        @(posedge pclk);
        `chk_eq("scl reset", 1'h0, scl_oe)
        `chk_eq("sda reset", 1'h0, sda_oe)
        presetn <= 1'h1;
        apb(1'h0, `REG_STATUS, 32'h0);
        `chk_eq("idle", 1'h0, q[`BIT_BUSY])
        $display("test midrun reset done");
        final_report;
    end
endmodule
`default_nettype wire

// *** testbench/i2c_slave_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       master_oe,
    input  wire logic [3:0] stretch,
    output logic            scl_hold
);
    // ****
    // slave holds scl low for stretch cycles after each release
    // ****
    logic [3:0] cnt_ff;
    logic       prev_ff;
    assign scl_hold = cnt_ff != 4'h0 || (prev_ff && !master_oe && stretch != 4'h0);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {cnt_ff, prev_ff} <= 5'h00;
        else
        begin
            prev_ff <= master_oe;
            if (prev_ff && !master_oe && stretch != 4'h0)
                cnt_ff <= stretch - 4'h1;
            else if (cnt_ff != 4'h0)
                cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule
`default_nettype wire
